// *** hw/pcpm_pkg.sv ***
package pcpm_pkg;
    // pin and function counts
    localparam int NPIN  = 20;   // crossbar pins p0.0 .. p2.3
    localparam int NF    = 19;   // routable signals, ids 1..NF
    localparam int NSLOT = 19;   // priority slots, slot 0 first
    localparam int FW    = 5;    // width of a pin index or function id

    typedef logic [FW-1:0] pcpm_id_t;

    // routing register addresses and reset values
    localparam logic [7:0] ROUTE0_ADDR  = 8'he1;
    localparam logic [7:0] ROUTE1_ADDR  = 8'he2;
    localparam logic [7:0] ROUTE0_RESET = 8'h00;
    localparam logic [7:0] ROUTE1_RESET = 8'h00;
    localparam logic [7:0] ROUTE1_WMASK = 8'hfb;  // bit 2 unused

    // crossbar_routing_control0 fields
    localparam int R0_UART   = 0;
    localparam int R0_SPI    = 1;
    localparam int R0_SMB0   = 2;
    localparam int R0_SYSCLK = 3;
    localparam int R0_CP0    = 4;
    localparam int R0_CP0A   = 5;
    localparam int R0_SMB1   = 6;
    localparam int R0_STRONG = 7;

    // crossbar_routing_control1 fields
    localparam int R1_CEX_LSB = 0;  // two-bit channel count
    localparam int R1_ECI     = 3;
    localparam int R1_T0      = 4;
    localparam int R1_T1      = 5;
    localparam int R1_XBAR    = 6;
    localparam int R1_PU_OFF  = 7;

    // function ids, 0 means plain port pin
    localparam pcpm_id_t F_NONE   = 5'h00;
    localparam pcpm_id_t F_TX     = 5'h01;
    localparam pcpm_id_t F_RX     = 5'h02;
    localparam pcpm_id_t F_SCK    = 5'h03;
    localparam pcpm_id_t F_MISO   = 5'h04;
    localparam pcpm_id_t F_MOSI   = 5'h05;
    localparam pcpm_id_t F_NSS    = 5'h06;
    localparam pcpm_id_t F_SDA0   = 5'h07;
    localparam pcpm_id_t F_SCL0   = 5'h08;
    localparam pcpm_id_t F_CP0    = 5'h09;
    localparam pcpm_id_t F_CP0A   = 5'h0a;
    localparam pcpm_id_t F_SYSCLK = 5'h0b;
    localparam pcpm_id_t F_CCH0   = 5'h0c;
    localparam pcpm_id_t F_CCH1   = 5'h0d;
    localparam pcpm_id_t F_CCH2   = 5'h0e;
    localparam pcpm_id_t F_ECI    = 5'h0f;
    localparam pcpm_id_t F_T0     = 5'h10;
    localparam pcpm_id_t F_T1     = 5'h11;
    localparam pcpm_id_t F_SDA1   = 5'h12;
    localparam pcpm_id_t F_SCL1   = 5'h13;

    // fixed serial port pins
    localparam pcpm_id_t TX_PIN = 5'h04;
    localparam pcpm_id_t RX_PIN = 5'h05;
endpackage : pcpm_pkg

// *** hw/pcpm_decoder.sv ***
`timescale 1ns/1ps
// combinational priority search: slot 0/1 is the fixed serial port pair,
// later slots take the lowest pin neither occupied nor skipped
module pcpm_decoder
    import pcpm_pkg::*;
(
    // slot requests, in priority order
    input  wire logic [NSLOT-1:0]   i_slot_en,
    input  wire pcpm_pkg::pcpm_id_t i_slot_id [NSLOT],
    input  wire logic [NPIN-1:0]    i_skip,
    // placement result
    output pcpm_pkg::pcpm_id_t      o_pin_func [NPIN],
    output pcpm_pkg::pcpm_id_t      o_func_pin [NF+1],
    output logic [NF:0]             o_placed
);
    // lowest free pin of an occupancy vector
    function automatic pcpm_id_t first_free(input logic [NPIN-1:0] occ);
        pcpm_id_t r;
        r = '0;
        for (int i = NPIN - 1; i >= 0; i--)
        begin
            if (!occ[i])
                r = FW'(i);
        end
        return r;
    endfunction : first_free

    logic [NPIN-1:0] occ;  // pins taken so far
    pcpm_id_t        p;    // pin picked for the current slot

    // one pass over the slots, highest priority first
    always_comb
    begin
        occ = i_skip;  // skipped pins count as taken
        p   = '0;
        o_placed = '0;
        for (int i = 0; i < NPIN; i++)
            o_pin_func[i] = F_NONE;
        for (int f = 0; f <= NF; f++)
            o_func_pin[f] = '0;
        // serial pair ignores the search
        if (i_slot_en[0])
        begin
            occ[TX_PIN]        = 1'b1;  // both pins claimed
            occ[RX_PIN]        = 1'b1;
            o_pin_func[TX_PIN] = F_TX;
            o_pin_func[RX_PIN] = F_RX;
            o_func_pin[F_TX]   = TX_PIN;
            o_func_pin[F_RX]   = RX_PIN;
            o_placed[F_TX]     = 1'b1;
            o_placed[F_RX]     = 1'b1;
        end
        // remaining slots in priority order
        for (int s = 2; s < NSLOT; s++)
        begin
            if (i_slot_en[s] && !(&occ))
            begin
                p                       = first_free(occ);
                occ[p]                  = 1'b1;  // later slots pass
                o_pin_func[p]           = i_slot_id[s];
                o_func_pin[i_slot_id[s]] = p;
                o_placed[i_slot_id[s]]  = 1'b1;
            end
        end
    end
endmodule : pcpm_decoder

// *** hw/pcpm_pad_cell.sv ***
`timescale 1ns/1ps
// one port pin: driver, weak pullup and input receiver
module pcpm_pad_cell
    import pcpm_pkg::*;
(
    // global settings
    input  wire logic i_xbar_en,
    input  wire logic i_weak_pu_dis,
    // per-pin settings
    input  wire logic i_digital,
    input  wire logic i_push_pull,
    input  wire logic i_smbus,
    // value to drive and whether the source wants to drive
    input  wire logic i_drv_val,
    input  wire logic i_drv_en,
    // pad side
    input  wire logic i_pad_in,
    output logic      o_pad_out,
    output logic      o_pad_oe,
    output logic      o_weak_pu,
    output logic      o_rx
);
    logic open_drain;  // high side driver disabled

    // smbus forces open-drain whatever the mode bit
    assign open_drain = i_smbus | ~i_push_pull;

    // driver: off until crossbar on, off for analog pins
    always_comb
    begin
        o_pad_out = i_drv_val;
        o_pad_oe  = i_xbar_en & i_digital & i_drv_en &
                    (~i_drv_val | ~open_drain);
    end

    // weak pullup; a disabled crossbar leaves the pin an input, so it
    // keeps its pullup like an open-drain pin
    assign o_weak_pu = i_digital & ~i_weak_pu_dis &
                       (~i_xbar_en | open_drain) &
                       ~(o_pad_oe & ~o_pad_out);

    // analog pins have their receiver off and read zero
    assign o_rx = i_digital & i_pad_in;
endmodule : pcpm_pad_cell

// *** hw/pcpm_top.sv ***
`timescale 1ns/1ps
module pcpm_top
    import pcpm_pkg::*;
(
    // clock and reset
    input  wire logic                  i_ref_clk,
    input  wire logic                  i_resetn,
    // special-function register port
    input  wire logic [7:0]            i_sfr_addr,
    input  wire logic                  i_sfr_wr,
    input  wire logic [7:0]            i_sfr_wdata,
    input  wire logic                  i_sfr_rd,
    output logic [7:0]                 o_sfr_rdata,
    // port configuration, one bit per pin
    input  wire logic [NPIN-1:0]       i_port_skip_mask,
    input  wire logic [NPIN-1:0]       i_port_input_mode,
    input  wire logic [NPIN-1:0]       i_port_output_mode,
    input  wire logic [NPIN-1:0]       i_port_data_out,
    output logic [NPIN-1:0]            o_port_data_in,
    // peripheral side settings
    input  wire logic [1:0]            i_spi_slave_select_mode,
    input  wire logic [1:0]            i_smbus_pin_swap,
    // peripheral signals, indexed by function id
    input  wire logic [pcpm_pkg::NF:1] i_func_out,
    input  wire logic [pcpm_pkg::NF:1] i_func_oe,
    output logic [pcpm_pkg::NF:1]      o_func_in,
    output logic [pcpm_pkg::NF:1]      o_func_routed,
    // pads
    input  wire logic [NPIN-1:0]       i_pad_in,
    output logic [NPIN-1:0]            o_pad_out,
    output logic [NPIN-1:0]            o_pad_oe,
    output logic [NPIN-1:0]            o_pad_weak_pullup,
    output logic [1:0]                 o_strong_pullup_en
);
    import pcpm_pkg::*;

    // true for the four smbus data and clock ids
    function automatic logic is_smbus(input pcpm_id_t f);
        return (f == F_SDA0) || (f == F_SCL0) ||
               (f == F_SDA1) || (f == F_SCL1);
    endfunction : is_smbus

    logic [7:0]      route0_q;       // crossbar_routing_control0
    logic [7:0]      route1_q;       // crossbar_routing_control1
    logic [7:0]      rdata_q;        // registered read data
    logic            xbar_en;        // crossbar_enable_bit
    logic            weak_pu_dis;    // weak_pullup_disable
    logic [1:0]      cex_sel;        // counter_array_route_sel
    logic            spi_four;       // spi uses its slave-select pin
    logic [NSLOT-1:0] slot_en;       // per-slot request
    pcpm_id_t        slot_id [NSLOT];
    pcpm_id_t        pin_func_d [NPIN];
    pcpm_id_t        func_pin_d [NF+1];
    logic [NF:0]     placed_d;
    pcpm_id_t        pin_func_q [NPIN];  // current pin map
    pcpm_id_t        func_pin_q [NF+1];  // pin of each function
    logic [NF:0]     placed_q;           // function has a pin
    logic [NPIN-1:0] rx;                 // digital receiver outputs

    // field views of the routing registers
    assign xbar_en     = route1_q[R1_XBAR];
    assign weak_pu_dis = route1_q[R1_PU_OFF];
    assign cex_sel     = route1_q[R1_CEX_LSB +: 2];
    // three-wire when the mode is 00, otherwise four wires
    assign spi_four    = |i_spi_slave_select_mode;

    // register writes; bit 2 of register 1 is not stored
    always_ff @(posedge i_ref_clk)
    begin
        if (!i_resetn)
        begin
            route0_q <= ROUTE0_RESET;
            route1_q <= ROUTE1_RESET;
        end
        else if (i_sfr_wr)
        begin
            if (i_sfr_addr == ROUTE0_ADDR)
                route0_q <= i_sfr_wdata;
            else if (i_sfr_addr == ROUTE1_ADDR)
                route1_q <= i_sfr_wdata & ROUTE1_WMASK;
        end
    end

    // read data, one cycle after the strobe; unmapped reads zero
    always_ff @(posedge i_ref_clk)
    begin
        if (!i_resetn)
            rdata_q <= 8'h00;
        else if (i_sfr_rd)
        begin
            case (i_sfr_addr)
                ROUTE0_ADDR: rdata_q <= route0_q;
                ROUTE1_ADDR: rdata_q <= route1_q;
                default:     rdata_q <= 8'h00;
            endcase
        end
    end

    assign o_sfr_rdata = rdata_q;

    // strong pullups for p2.2 and p2.3
    assign o_strong_pullup_en = {2{route0_q[R0_STRONG]}};

    // slot table in priority order; pairs claim both pins
    always_comb
    begin
        slot_en     = '0;
        slot_id[0]  = F_TX;
        slot_id[1]  = F_RX;
        slot_id[2]  = F_SCK;
        slot_id[3]  = F_MISO;
        slot_id[4]  = F_MOSI;
        slot_id[5]  = F_NSS;
        // swap puts clock before data
        slot_id[6]  = i_smbus_pin_swap[0] ? F_SCL0 : F_SDA0;
        slot_id[7]  = i_smbus_pin_swap[0] ? F_SDA0 : F_SCL0;
        slot_id[8]  = F_CP0;
        slot_id[9]  = F_CP0A;
        slot_id[10] = F_SYSCLK;
        slot_id[11] = F_CCH0;
        slot_id[12] = F_CCH1;
        slot_id[13] = F_CCH2;
        slot_id[14] = F_ECI;
        slot_id[15] = F_T0;
        slot_id[16] = F_T1;
        slot_id[17] = i_smbus_pin_swap[1] ? F_SCL1 : F_SDA1;
        slot_id[18] = i_smbus_pin_swap[1] ? F_SDA1 : F_SCL1;
        slot_en[1:0]   = {2{route0_q[R0_UART]}};
        slot_en[4:2]   = {3{route0_q[R0_SPI]}};
        slot_en[5]     = route0_q[R0_SPI] & spi_four;
        slot_en[7:6]   = {2{route0_q[R0_SMB0]}};
        slot_en[8]     = route0_q[R0_CP0];
        slot_en[9]     = route0_q[R0_CP0A];
        slot_en[10]    = route0_q[R0_SYSCLK];
        // channel count 00 none .. 11 three channels
        slot_en[11]    = cex_sel != 2'b00;
        slot_en[12]    = cex_sel[1];
        slot_en[13]    = cex_sel == 2'b11;
        slot_en[14]    = route1_q[R1_ECI];
        slot_en[15]    = route1_q[R1_T0];
        slot_en[16]    = route1_q[R1_T1];
        slot_en[18:17] = {2{route0_q[R0_SMB1]}};
    end

    // priority search over the current settings
    pcpm_decoder u_decoder (
        .i_slot_en  (slot_en),
        .i_slot_id  (slot_id),
        .i_skip     (i_port_skip_mask),
        .o_pin_func (pin_func_d),
        .o_func_pin (func_pin_d),
        .o_placed   (placed_d)
    );

    // map recomputed every clock, so any change lands next edge; the
    // register also cuts the long search path off the pad drivers
    always_ff @(posedge i_ref_clk)
    begin
        if (!i_resetn)
        begin
            placed_q <= '0;
            for (int i = 0; i < NPIN; i++)
                pin_func_q[i] <= F_NONE;
            for (int f = 0; f <= NF; f++)
                func_pin_q[f] <= '0;
        end
        else
        begin
            placed_q   <= placed_d;
            pin_func_q <= pin_func_d;
            func_pin_q <= func_pin_d;
        end
    end

    // one pad cell per pin
    generate
        for (genvar g = 0; g < NPIN; g++)
        begin : g_pin
            pcpm_id_t fid;     // function on this pin
            logic     routed;  // pin carries a peripheral
            logic     drv_val;
            logic     drv_en;

            // routing counts only with the crossbar on
            assign fid    = pin_func_q[g];
            assign routed = xbar_en && (fid != F_NONE);

            // unrouted pins are plain port pins
            always_comb
            begin
                if (routed)
                begin
                    drv_val = i_func_out[fid];
                    drv_en  = i_func_oe[fid];
                end
                else
                begin
                    drv_val = i_port_data_out[g];
                    drv_en  = 1'b1;
                end
            end

            pcpm_pad_cell u_cell (
                .i_xbar_en     (xbar_en),
                .i_weak_pu_dis (weak_pu_dis),
                .i_digital     (i_port_input_mode[g]),
                .i_push_pull   (i_port_output_mode[g]),
                .i_smbus       (routed && is_smbus(fid)),
                .i_drv_val     (drv_val),
                .i_drv_en      (drv_en),
                .i_pad_in      (i_pad_in[g]),
                .o_pad_out     (o_pad_out[g]),
                .o_pad_oe      (o_pad_oe[g]),
                .o_weak_pu     (o_pad_weak_pullup[g]),
                .o_rx          (rx[g])
            );
        end
    endgenerate

    assign o_port_data_in = rx;

    // peripheral inputs idle high when the function has no pin
    generate
        for (genvar f = 1; f <= NF; f++)
        begin : g_func
            assign o_func_routed[f] = xbar_en & placed_q[f];
            assign o_func_in[f]     = o_func_routed[f] ?
                                      rx[func_pin_q[f]] : 1'b1;
        end
    endgenerate

    // helper views for the checks below
    logic [NPIN-1:0] smb_pin;    // pin carries smbus
    logic [NPIN-1:0] placed_pin; // pin carries a searched function
    always_comb
    begin
        for (int i = 0; i < NPIN; i++)
        begin
            smb_pin[i]    = is_smbus(pin_func_q[i]);
            placed_pin[i] = (pin_func_q[i] != F_NONE) &&
                            (pin_func_q[i] != F_TX) &&
                            (pin_func_q[i] != F_RX);
        end
    end

    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (!i_resetn);

    xbar_off_drv_a: assert property (
        !xbar_en |-> o_pad_oe == '0)
        else $error("driver on while crossbar disabled");

    uart_fixed_a: assert property (
        route0_q[R0_UART] ##1 route0_q[R0_UART] |->
        pin_func_q[TX_PIN] == F_TX && pin_func_q[RX_PIN] == F_RX)
        else $error("serial port not on its fixed pins");

    skip_honour_a: assert property (
        (placed_pin & $past(i_port_skip_mask)) == '0)
        else $error("searched function placed on skipped pin");

    analog_off_a: assert property (
        ((o_pad_oe | o_pad_weak_pullup | rx) & ~i_port_input_mode) == '0)
        else $error("analog pin has digital circuits on");

    smbus_od_a: assert property (
        xbar_en |-> (smb_pin & o_pad_oe & o_pad_out) == '0)
        else $error("smbus pin driven high");

    pullup_low_a: assert property (
        (o_pad_weak_pullup & o_pad_oe & ~o_pad_out) == '0)
        else $error("weak pullup on while driving zero");

    pushpull_pu_a: assert property (
        xbar_en |-> (o_pad_weak_pullup & i_port_output_mode & ~smb_pin &
        (placed_pin | ~placed_pin)) == '0)
        else $error("weak pullup on push-pull pin");

    strong_pu_a: assert property (
        i_sfr_wr && i_sfr_addr == ROUTE0_ADDR |=>
        o_strong_pullup_en == {2{$past(i_sfr_wdata[R0_STRONG])}})
        else $error("strong pullup does not follow bit 7");

    route1_rsvd_a: assert property (
        i_sfr_rd && i_sfr_addr == ROUTE1_ADDR |=> !o_sfr_rdata[2])
        else $error("unused bit of register 1 reads one");

    cex_count_a: assert property (
        cex_sel == 2'b01 && $stable(cex_sel) && !(&$past(slot_en[10:2]))
        |-> !placed_q[F_CCH1] && !placed_q[F_CCH2])
        else $error("extra counter channel routed");

    map_update_a: assert property (
        $changed(route0_q) |=> placed_q == $past(placed_d))
        else $error("pin map not updated after one clock");
endmodule : pcpm_top

// *** tb/pcpm_pin_model.sv ***
`timescale 1ns/1ps
// external pins: device drive wins, else board drive, else pullups
module pcpm_pin_model
    import pcpm_pkg::*;
(
    // clock
    input  wire logic            i_clk,
    // device pad side
    input  wire logic [NPIN-1:0] i_pad_out,
    input  wire logic [NPIN-1:0] i_pad_oe,
    input  wire logic [NPIN-1:0] i_pull,
    // board drivers
    input  wire logic [NPIN-1:0] i_ext_en,
    input  wire logic [NPIN-1:0] i_ext_val,
    output logic [NPIN-1:0]      o_pad_in
);
    logic [NPIN-1:0] float_q = '0;   // level of a pin nobody holds

    // a floating pin flips every cycle so a stale level never looks valid
    always_ff @(posedge i_clk)
    begin
        float_q <= ~o_pad_in;
    end

    // pad level resolution
    always_comb
    begin
        o_pad_in = (i_pad_oe & i_pad_out)
                 | (~i_pad_oe & i_ext_en & i_ext_val)
                 | (~i_pad_oe & ~i_ext_en & (i_pull | float_q));
    end
endmodule : pcpm_pin_model

// *** tb/priority_crossbar_pin_mux_test.sv ***
`timescale 1ns/1ps
module priority_crossbar_pin_mux_test;
    import pcpm_pkg::*;
    logic            clk = 1'b0;      // 200 MHz
    logic            resetn = 1'b0;   // active low
    logic [7:0]      addr = 8'h00;
    logic            wr = 1'b0;
    logic [7:0]      wdata = 8'h00;
    logic            rd = 1'b0;
    logic [7:0]      rdata;
    logic [NPIN-1:0] skip = '0;
    logic [NPIN-1:0] im = '1;         // all digital, as after reset
    logic [NPIN-1:0] om = '0;         // open-drain lets oe reveal a zero
    logic [NPIN-1:0] dout = '1;
    logic [NPIN-1:0] din, pad_in, pad_out, pad_oe, wpu, ext_en, ext_val;
    logic [1:0]      ssm = 2'h0;
    logic [1:0]      swap = 2'h0;
    logic [NF:1]     fout = '1;
    logic [NF:1]     foe = '1;
    logic [NF:1]     fin, frt;
    logic [1:0]      spu;
    logic [19:0]     v, e_oe, e_pu;
    logic [7:0]      r;
    int              miscompares = 0;
    int              comparisons = 0;

    always #2.5 clk = ~clk;
    assign ext_en = '0;

    pcpm_top u_pcpm_top (.i_ref_clk(clk), .i_resetn(resetn),
        .i_sfr_addr(addr), .i_sfr_wr(wr), .i_sfr_wdata(wdata),
        .i_sfr_rd(rd), .o_sfr_rdata(rdata), .i_port_skip_mask(skip),
        .i_port_input_mode(im), .i_port_output_mode(om),
        .i_port_data_out(dout), .o_port_data_in(din),
        .i_spi_slave_select_mode(ssm), .i_smbus_pin_swap(swap),
        .i_func_out(fout), .i_func_oe(foe), .o_func_in(fin),
        .o_func_routed(frt), .i_pad_in(pad_in), .o_pad_out(pad_out),
        .o_pad_oe(pad_oe), .o_pad_weak_pullup(wpu),
        .o_strong_pullup_en(spu));

    pcpm_pin_model u_pcpm_pin_model (.i_clk(clk), .i_pad_out(pad_out),
        .i_pad_oe(pad_oe), .i_pull(wpu | {spu, 18'h0}), .i_ext_en(ext_en),
        .i_ext_val(ext_val), .o_pad_in(pad_in));

    // inputs always move 1 ns after a rising edge
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : tick

    task automatic chk(input logic [19:0] got, input logic [19:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            miscompares++;
            $display("Error t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : chk

    // map settles one edge after the write edge; the task waits two
    task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
        addr = a;
        wdata = d;
        wr = 1'b1;
        tick(1);
        wr = 1'b0;
        tick(2);
    endtask : reg_wr

    task automatic reg_rd(input logic [7:0] a, output logic [7:0] d);
        addr = a;
        rd = 1'b1;
        tick(1);
        rd = 1'b0;
        d = rdata;
        tick(1);
    endtask : reg_rd

    // only function f drives a zero, so oe marks its pin alone
    task automatic probe(input int f, input int pin);
        fout = ~(19'h1 << (f - 1));
        tick(1);
        chk(pad_oe, (pin < 0) ? 20'h0 : (20'h1 << pin));
        // routed functions read their own pin, unrouted ones read one
        chk({1'b0, fin}, {1'b0, (pin < 0) ? 19'h7ffff : fout});
        fout = '1;
        tick(1);
    endtask : probe

    task automatic t_reset;
        reg_rd(ROUTE0_ADDR, r);
        chk({12'h0, r}, 20'h0);
        reg_rd(ROUTE1_ADDR, r);
        chk({12'h0, r}, 20'h0);
        chk(pad_oe, 20'h0);
        chk({1'b0, frt}, 20'h0);
        chk(wpu, 20'hfffff);
        chk({18'h0, spu}, 20'h0);
        $display("test reset done");
    endtask : t_reset

    // unused bit 2 and an unmapped address both read zero
    task automatic t_regs;
        reg_wr(ROUTE1_ADDR, 8'hbf);
        reg_wr(8'h10, 8'h55);
        reg_rd(ROUTE1_ADDR, r);
        chk({12'h0, r}, 20'hbb);
        reg_rd(8'h10, r);
        chk({12'h0, r}, 20'h0);
        reg_wr(ROUTE1_ADDR, 8'h00);
        $display("test regs done");
    endtask : t_regs

    // skipped oscillator pins, serial, smbus0 and one counter channel
    task automatic t_walk;
        skip = 20'h0000c;
        reg_wr(ROUTE0_ADDR, 8'h05);
        reg_wr(ROUTE1_ADDR, 8'h41);
        chk({1'b0, frt}, 20'h008c3);
        probe(F_TX, 4);
        probe(F_RX, 5);
        probe(F_SDA0, 0);
        probe(F_SCL0, 1);
        probe(F_CCH0, 6);
        probe(F_CCH1, -1);
        dout = 20'hfff7f;
        tick(1);
        chk(pad_oe, 20'h00080);
        dout = '1;
        skip = '0;
        probe(F_CCH0, 2);
        $display("test walk done");
    endtask : t_walk

    // spi around the fixed serial pins, four then three wires, swap
    task automatic t_spi;
        reg_wr(ROUTE1_ADDR, 8'h40);
        ssm = 2'h1;
        reg_wr(ROUTE0_ADDR, 8'h07);
        probe(F_SCK, 0);
        probe(F_NSS, 3);
        probe(F_SDA0, 6);
        probe(F_SCL0, 7);
        ssm = 2'h0;
        tick(1);
        chk({1'b0, frt}, 20'h000df);
        probe(F_MOSI, 2);
        probe(F_SDA0, 3);
        swap = 2'h1;
        probe(F_SCL0, 3);
        probe(F_SDA0, 6);
        swap = 2'h0;
        $display("test spi done");
    endtask : t_spi

    // every counter field code, timer inputs, then the other sources
    task automatic t_cex;
        reg_wr(ROUTE0_ADDR, 8'h00);
        for (int k = 0; k < 4; k++)
        begin
            reg_wr(ROUTE1_ADDR, 8'h78 | 8'(k));
            v = (((20'h1 << k) - 1) << 11) | 20'h1c000;
            chk({1'b0, frt}, v);
        end
        probe(F_CCH2, 2);
        probe(F_T1, 5);
        reg_wr(ROUTE1_ADDR, 8'h42);
        reg_wr(ROUTE0_ADDR, 8'h78);
        chk({1'b0, frt}, 20'h61f00);
        probe(F_CP0A, 1);
        probe(F_SYSCLK, 2);
        probe(F_CCH1, 4);
        probe(F_SCL1, 6);
        $display("test cex done");
    endtask : t_cex

    // crossbar off: nothing routed or driven whatever is asked
    task automatic t_off;
        reg_wr(ROUTE1_ADDR, 8'h03);
        dout = '0;
        fout = '0;
        tick(1);
        chk({1'b0, frt}, 20'h0);
        chk(pad_oe, 20'h0);
        dout = '1;
        fout = '1;
        $display("test off done");
    endtask : t_off

    // pad cells; smbus0 on pins 0 and 1, pin 4 analog
    task automatic t_pads;
        reg_wr(ROUTE0_ADDR, 8'h04);
        reg_wr(ROUTE1_ADDR, 8'h40);
        im = 20'hfffef;
        om = 20'h0f0ff;
        dout = 20'h5aa5a;
        tick(1);
        for (int p = 0; p < NPIN; p++)
        begin
            v[p] = (p < 2) ? 1'b1 : dout[p];
            e_oe[p] = im[p] & ((om[p] & (p >= 2)) | ~v[p]);
            e_pu[p] = im[p] & ~(om[p] & (p >= 2)) & v[p];
        end
        chk(pad_oe, e_oe);
        chk(wpu, e_pu);
        chk(din, im & pad_in);
        chk(pad_out & e_oe, v & e_oe);
        reg_wr(ROUTE1_ADDR, 8'hc0);
        chk(wpu, 20'h0);
        im = '1;
        om = '0;
        dout = '1;
        $display("test pads done");
    endtask : t_pads

    task automatic t_strong;
        reg_wr(ROUTE0_ADDR, 8'h80);
        chk({18'h0, spu}, 20'h3);
        reg_wr(ROUTE0_ADDR, 8'h00);
        chk({18'h0, spu}, 20'h0);
        $display("test strong done");
    endtask : t_strong

    task automatic summarize;
        $display("compares %0d mismatches %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : summarize

    // bounded run: a hang counts as a mismatch
    initial
    begin
        repeat (20000) @(posedge clk);
        miscompares++;
        summarize();
    end

    initial
    begin
        ext_val = 20'h3c5a6;
        tick(8);
        resetn = 1'b1;
        t_reset();
        t_regs();
        t_walk();
        t_spi();
        t_cex();
        t_off();
        t_pads();
        t_strong();
        summarize();
    end
endmodule : priority_crossbar_pin_mux_test
